// file: verilog/aux_ref_cal_config_regs.sv
// avalon register slice for aux level, reference trim and calibration control
`timescale 1ns/1ps
`include "cal_params.svh"
module aux_ref_cal_config_regs
  import cal_pkg::*;
#(
  parameter logic [15:0] CAL_TICKS  = `CAL_TICKS_DEFAULT,
  parameter int          MEM_DEPTH  = 64
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // avalon-mm slave
  input  wire logic [9:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic [31:0] writedata_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  // analog controls
  output logic [9:0]       aux_i_level_o,
  output logic             aux_i_output_on_o,
  output logic [1:0]       aux_i_span_sel_o,
  output logic [2:0]       aux_i_ceiling_sel_o,
  output logic [5:0]       reference_trim_code_o,
  output logic             calib_clock_tick_o,
  output logic             q_calib_busy_o,
  output logic             i_calib_busy_o,
  output logic [5:0]       q_calib_ref_o,
  output logic [5:0]       i_calib_ref_o
);
  // bus state
  logic        ack_reg;
  logic [31:0] readdata_reg;

  // register storage
  logic [7:0]  aux_i_level_low_reg;
  logic [7:0]  aux_i_control_reg;
  logic [5:0]  reference_trim_reg;
  logic [7:0]  calibration_control_reg;
  logic [5:0]  coeff_mem_pointer_reg;
  logic [5:0]  coeff_mem_word_reg;
  logic [5:0]  coeff_mem_word_next;
  logic        q_calib_done_reg;
  logic        q_calib_done_next;
  logic        i_calib_done_reg;
  logic        i_calib_done_next;
  logic [1:0]  q_coeff_state_reg;
  logic [1:0]  q_coeff_state_next;
  logic [1:0]  i_coeff_state_reg;
  logic [1:0]  i_coeff_state_next;

  // static coefficient memory
  logic [5:0]  coeff_mem [MEM_DEPTH];

  // decode
  wire  [7:0]  reg_index;
  wire         request;
  wire         write_commit;
  wire         read_capture;
  wire         low_lane;
  wire         wr_level_low;
  wire         wr_aux_control;
  wire         wr_ref_trim;
  wire         wr_cal_control;
  wire         wr_mem_pointer;
  wire         wr_mem_word;
  wire         wr_command;
  wire  [7:0]  wr_byte;
  wire  [7:0]  calibration_status;
  logic [7:0]  read_mux;

  // command strobes
  wire         selfcal_launch;
  wire         coeff_store_cmd;
  wire         coeff_load_cmd;
  wire         q_coeff_restore;
  wire         i_coeff_restore;
  wire         q_done_clear;
  wire         i_done_clear;

  // calibration fields
  wire         q_preload_source;
  wire         i_preload_source;
  wire         q_selfcal_select;
  wire         i_selfcal_select;
  wire         calib_clock_gate;
  wire  [2:0]  calib_clock_divider;
  wire  [5:0]  user_preload;
  wire  [5:0]  q_preload;
  wire  [5:0]  i_preload;
  wire         q_start;
  wire         i_start;
  wire         q_finish;
  wire         i_finish;

  // byte address to register index; low two address bits ignored
  assign reg_index    = address_i[9:2];
  assign request      = read_i || write_i;
  assign write_commit = write_i && ack_reg;
  assign read_capture = read_i && !ack_reg;
  assign low_lane     = byteenable_i[0];
  assign wr_byte      = writedata_i[7:0];

  // one wait state on every access keeps read data registered
  assign waitrequest_o = request && !ack_reg;
  assign readdata_o    = readdata_reg;

  // per-register write strobes, only the low byte lane carries data
  assign wr_level_low   = write_commit && low_lane && (reg_index == `AUX_LEVEL_LOW_IDX);
  assign wr_aux_control = write_commit && low_lane && (reg_index == `AUX_CONTROL_IDX);
  assign wr_ref_trim    = write_commit && low_lane && (reg_index == `REF_TRIM_IDX);
  assign wr_cal_control = write_commit && low_lane && (reg_index == `CAL_CONTROL_IDX);
  assign wr_mem_pointer = write_commit && low_lane && (reg_index == `MEM_POINTER_IDX);
  assign wr_mem_word    = write_commit && low_lane && (reg_index == `MEM_WORD_IDX);
  assign wr_command     = write_commit && low_lane && (reg_index == `MEM_COMMAND_IDX);

  // command bits act only in the write cycle; writing zero does nothing
  assign selfcal_launch  = wr_command && wr_byte[`LAUNCH_BIT];
  assign coeff_store_cmd = wr_command && wr_byte[`STORE_BIT];
  assign coeff_load_cmd  = wr_command && wr_byte[`LOAD_BIT];
  assign q_coeff_restore = wr_command && wr_byte[`Q_RESTORE_BIT];
  assign i_coeff_restore = wr_command && wr_byte[`I_RESTORE_BIT];
  assign q_done_clear    = wr_command && wr_byte[`Q_DONE_CLR_BIT];
  assign i_done_clear    = wr_command && wr_byte[`I_DONE_CLR_BIT];

  // calibration control fields
  assign q_preload_source    = calibration_control_reg[`Q_PRELOAD_BIT];
  assign i_preload_source    = calibration_control_reg[`I_PRELOAD_BIT];
  assign q_selfcal_select    = calibration_control_reg[`Q_SELECT_BIT];
  assign i_selfcal_select    = calibration_control_reg[`I_SELECT_BIT];
  assign calib_clock_gate    = calibration_control_reg[`CLOCK_GATE_BIT];
  assign calib_clock_divider = calibration_control_reg[`DIVIDER_HI:`DIVIDER_LO];

  // preload: fixed reference or the user word held at memory location one
  assign user_preload = coeff_mem[`USER_PRELOAD_ADDR];
  assign q_preload    = q_preload_source ? user_preload : `DEFAULT_PRELOAD;
  assign i_preload    = i_preload_source ? user_preload : `DEFAULT_PRELOAD;
  assign q_start      = selfcal_launch && q_selfcal_select;
  assign i_start      = selfcal_launch && i_selfcal_select;

  // analog control outputs straight from the register fields
  assign aux_i_level_o = {aux_i_control_reg[`AUX_LEVEL_HI_HI:`AUX_LEVEL_HI_LO], aux_i_level_low_reg};
  assign aux_i_output_on_o     = aux_i_control_reg[`AUX_ON_BIT];
  assign aux_i_span_sel_o      = aux_i_control_reg[`AUX_SPAN_HI:`AUX_SPAN_LO];
  assign aux_i_ceiling_sel_o   = aux_i_control_reg[`AUX_CEIL_HI:`AUX_CEIL_LO];
  assign reference_trim_code_o = reference_trim_reg;

  // status packing; bits 5:4 read zero
  assign calibration_status = {q_calib_done_reg, i_calib_done_reg, 2'b00,
                               q_coeff_state_reg, i_coeff_state_reg};

  // read selection; command register and unmapped indices read zero
  always_comb begin
    read_mux = 8'h00;
    case (reg_index)
      `AUX_LEVEL_LOW_IDX: begin
        read_mux = aux_i_level_low_reg;
      end
      `AUX_CONTROL_IDX: begin
        read_mux = aux_i_control_reg;
      end
      `REF_TRIM_IDX: begin
        read_mux = {2'b00, reference_trim_reg};
      end
      `CAL_CONTROL_IDX: begin
        read_mux = calibration_control_reg;
      end
      `CAL_STATUS_IDX: begin
        read_mux = calibration_status;
      end
      `MEM_POINTER_IDX: begin
        read_mux = {2'b00, coeff_mem_pointer_reg};
      end
      `MEM_WORD_IDX: begin
        read_mux = {2'b00, coeff_mem_word_reg};
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
  end

  // bus handshake and read capture
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= request && !ack_reg;
      if (read_capture) begin
        readdata_reg <= {24'h00_0000, read_mux};
      end
    end
  end

  // plain configuration registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      aux_i_level_low_reg     <= `REG8_RESET;
      aux_i_control_reg       <= `REG8_RESET;
      reference_trim_reg      <= `WORD6_RESET;
      calibration_control_reg <= `REG8_RESET;
      coeff_mem_pointer_reg   <= `WORD6_RESET;
    end else begin
      if (wr_level_low) begin
        aux_i_level_low_reg <= wr_byte;
      end
      if (wr_aux_control) begin
        aux_i_control_reg <= wr_byte;
      end
      if (wr_ref_trim) begin
        reference_trim_reg <= wr_byte[5:0];
      end
      if (wr_cal_control) begin
        calibration_control_reg <= wr_byte;
      end
      if (wr_mem_pointer) begin
        coeff_mem_pointer_reg <= wr_byte[5:0];
      end
    end
  end

  // data word: a load command overrides a plain write in the same cycle
  always_comb begin
    coeff_mem_word_next = coeff_mem_word_reg;
    if (coeff_load_cmd) begin
      coeff_mem_word_next = coeff_mem[coeff_mem_pointer_reg];
    end else if (wr_mem_word) begin
      coeff_mem_word_next = wr_byte[5:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      coeff_mem_word_reg <= `WORD6_RESET;
    end else begin
      coeff_mem_word_reg <= coeff_mem_word_next;
    end
  end

  // coefficient memory, one generate entry per word so each clears at reset
  genvar entry;
  generate
    for (entry = 0; entry < MEM_DEPTH; entry++) begin : g_coeff
      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          coeff_mem[entry] <= `WORD6_RESET;
        end else if (coeff_store_cmd && (coeff_mem_pointer_reg == 6'(entry))) begin
          coeff_mem[entry] <= coeff_mem_word_reg;
        end
      end
    end
  endgenerate

  // done flags: launch or clear drops a flag, a finish in the same cycle wins
  always_comb begin
    q_calib_done_next = q_calib_done_reg;
    i_calib_done_next = i_calib_done_reg;
    if (q_start || q_done_clear) begin
      q_calib_done_next = 1'b0;
    end
    if (i_start || i_done_clear) begin
      i_calib_done_next = 1'b0;
    end
    if (q_finish) begin
      q_calib_done_next = 1'b1;
    end
    if (i_finish) begin
      i_calib_done_next = 1'b1;
    end
  end

  // coefficient state: store marks selected channels user, finish marks self
  always_comb begin
    q_coeff_state_next = q_coeff_state_reg;
    i_coeff_state_next = i_coeff_state_reg;
    if (q_coeff_restore) begin
      q_coeff_state_next = `STATE_UNCAL;
    end
    if (i_coeff_restore) begin
      i_coeff_state_next = `STATE_UNCAL;
    end
    if (coeff_store_cmd && q_selfcal_select) begin
      q_coeff_state_next = `STATE_USER;
    end
    if (coeff_store_cmd && i_selfcal_select) begin
      i_coeff_state_next = `STATE_USER;
    end
    if (q_finish) begin
      q_coeff_state_next = `STATE_SELF;
    end
    if (i_finish) begin
      i_coeff_state_next = `STATE_SELF;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      q_calib_done_reg  <= 1'b0;
      i_calib_done_reg  <= 1'b0;
      q_coeff_state_reg <= `STATE_UNCAL;
      i_coeff_state_reg <= `STATE_UNCAL;
    end else begin
      q_calib_done_reg  <= q_calib_done_next;
      i_calib_done_reg  <= i_calib_done_next;
      q_coeff_state_reg <= q_coeff_state_next;
      i_coeff_state_reg <= i_coeff_state_next;
    end
  end

  // calibration clock; with the gate off a running calibration simply stalls
  calib_clock_divider_gen u_divider (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .gate_i    (calib_clock_gate),
    .code_i    (calib_clock_divider),
    .tick_o    (calib_clock_tick_o)
  );

  // quadrature channel sequencer
  calib_channel_seq #(
    .CAL_TICKS (CAL_TICKS)
  ) u_q_seq (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .start_i   (q_start),
    .abort_i   (q_coeff_restore),
    .tick_i    (calib_clock_tick_o),
    .preload_i (q_preload),
    .busy_o    (q_calib_busy_o),
    .finish_o  (q_finish),
    .ref_o     (q_calib_ref_o)
  );

  // in-phase channel sequencer
  calib_channel_seq #(
    .CAL_TICKS (CAL_TICKS)
  ) u_i_seq (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .start_i   (i_start),
    .abort_i   (i_coeff_restore),
    .tick_i    (calib_clock_tick_o),
    .preload_i (i_preload),
    .busy_o    (i_calib_busy_o),
    .finish_o  (i_finish),
    .ref_o     (i_calib_ref_o)
  );
endmodule

// file: verilog/cal_params.svh
// offsets, field positions, reset values and codes of the aux, reference and calibration registers
// Functional notes
// - level word bits 7:0 at 0x0B, reset zero
// - level 3ff full, 200 mid, 000 bottom
// - control bit 7 enables aux output, reset off
// - span bits 6:5: 2V, 1.5V, 1V, 0.5V
// - ceiling bits 4:2: 1.0 to 2.9 V
// - level word bits 9:8 in control 1:0
// - six-bit two's complement reference trim at 0x0D
// - q preload: zero fixed 32, one user
// - i preload: zero fixed 32, one user
// - bits 5/4 select q/i self-calibration
// - bit 3 gates calibration clock, reset off
// - divider 000=/256, 001=/128, 110=/4, 111=/2
// - status 0x0F bits 7/6 report done
// - coefficient state 00 uncal, 01 self, 10 user
// - 0x10 bits 5:0 hold memory address
// - 0x11 bits 5:0 hold memory data word
// - launch bit one starts selected self-calibration
// - store command writes data word at address
// - load command reads addressed word into data
// - q restore returns q coefficients to uncalibrated
`ifndef CAL_PARAMS_SVH
`define CAL_PARAMS_SVH

// register indices; byte address is four times the index
`define AUX_LEVEL_LOW_IDX   8'h0b
`define AUX_CONTROL_IDX     8'h0c
`define REF_TRIM_IDX        8'h0d
`define CAL_CONTROL_IDX     8'h0e
`define CAL_STATUS_IDX      8'h0f
`define MEM_POINTER_IDX     8'h10
`define MEM_WORD_IDX        8'h11
`define MEM_COMMAND_IDX     8'h12

// aux control fields
`define AUX_ON_BIT          7
`define AUX_SPAN_HI         6
`define AUX_SPAN_LO         5
`define AUX_CEIL_HI         4
`define AUX_CEIL_LO         2
`define AUX_LEVEL_HI_HI     1
`define AUX_LEVEL_HI_LO     0

// calibration control fields
`define Q_PRELOAD_BIT       7
`define I_PRELOAD_BIT       6
`define Q_SELECT_BIT        5
`define I_SELECT_BIT        4
`define CLOCK_GATE_BIT      3
`define DIVIDER_HI          2
`define DIVIDER_LO          0

// status fields
`define Q_DONE_BIT          7
`define I_DONE_BIT          6
`define Q_STATE_HI          3
`define Q_STATE_LO          2
`define I_STATE_HI          1
`define I_STATE_LO          0

// command register bits, write one to act
`define Q_DONE_CLR_BIT      7
`define I_DONE_CLR_BIT      6
`define LAUNCH_BIT          4
`define STORE_BIT           3
`define LOAD_BIT            2
`define Q_RESTORE_BIT       1
`define I_RESTORE_BIT       0

// reset values and codes
`define REG8_RESET          8'h00
`define WORD6_RESET         6'h00
`define DEFAULT_PRELOAD     6'h20
`define USER_PRELOAD_ADDR   6'h01
`define STATE_UNCAL         2'h0
`define STATE_SELF          2'h1
`define STATE_USER          2'h2
`define DIVIDE_BASE         9'h100
`define CAL_TICKS_DEFAULT   16'h0040

`endif

// file: verilog/cal_pkg.sv
// types shared by the calibration register slice
package cal_pkg;
  // one-hot states of a channel calibration sequencer
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN  = 2'b10
  } cal_state_type;
endpackage

// file: verilog/calib_clock_divider_gen.sv
// calibration clock enable: power-of-two divider of the system clock
`timescale 1ns/1ps
`include "cal_params.svh"
module calib_clock_divider_gen (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       gate_i,
  input  wire logic [2:0] code_i,
  output logic            tick_o
);
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [8:0] ratio;
  wire  [7:0] last_count;
  wire        wrap;

  // ratio is 256 shifted down by the code, so 000 gives 256 and 111 gives 2
  assign ratio      = `DIVIDE_BASE >> code_i;
  assign last_count = 8'(ratio - 9'h001);
  assign wrap       = gate_i && (count_reg == last_count);
  assign count_next = (!gate_i || wrap) ? 8'h00 : 8'(count_reg + 8'h01);

  // counter held at zero while gated off so each enable starts a full period
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      count_reg <= 8'h00;
      tick_o    <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_o    <= wrap;
    end
  end
endmodule

// file: verilog/calib_channel_seq.sv
// per-channel self-calibration sequencer counting calibration clock ticks
`timescale 1ns/1ps
`include "cal_params.svh"
module calib_channel_seq
  import cal_pkg::*;
#(
  parameter logic [15:0] CAL_TICKS = `CAL_TICKS_DEFAULT
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic       tick_i,
  input  wire logic [5:0] preload_i,
  output logic            busy_o,
  output logic            finish_o,
  output logic [5:0]      ref_o
);
  cal_state_type state_reg;
  cal_state_type state_next;
  logic [15:0]   ticks_reg;
  logic [15:0]   ticks_next;
  wire           last_tick;

  assign last_tick = tick_i && (ticks_reg == 16'(CAL_TICKS - 16'h0001));

  // sequencing: runs only while the gated calibration clock ticks
  always_comb begin
    state_next = state_reg;
    ticks_next = ticks_reg;
    case (state_reg)
      CAL_IDLE: begin
        if (start_i) begin
          state_next = CAL_RUN;
          ticks_next = 16'h0000;
        end
      end
      CAL_RUN: begin
        if (abort_i || last_tick) begin
          state_next = CAL_IDLE;
        end else if (tick_i) begin
          ticks_next = 16'(ticks_reg + 16'h0001);
        end
      end
      default: begin
        state_next = CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_reg <= CAL_IDLE;
      ticks_reg <= 16'h0000;
      finish_o  <= 1'b0;
      ref_o     <= `DEFAULT_PRELOAD;
    end else begin
      state_reg <= state_next;
      ticks_reg <= ticks_next;
      finish_o  <= (state_reg == CAL_RUN) && last_tick && !abort_i;
      if (state_reg == CAL_IDLE && start_i) begin
        ref_o <= preload_i;
      end
    end
  end

  assign busy_o = (state_reg == CAL_RUN);
endmodule

// file: test/aux_ref_cal_checker.sv
// concurrent checks on the aux level, reference trim and calibration ports
`timescale 1ns/1ps
module aux_ref_cal_checker #(
  parameter logic [15:0] CAL_TICKS = 16'h0040
) (
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic [9:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [3:0]  byteenable_i,
  input wire logic [31:0] writedata_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic [9:0]  aux_i_level_o,
  input wire logic        aux_i_output_on_o,
  input wire logic [1:0]  aux_i_span_sel_o,
  input wire logic [2:0]  aux_i_ceiling_sel_o,
  input wire logic [5:0]  reference_trim_code_o,
  input wire logic        calib_clock_tick_o,
  input wire logic        q_calib_busy_o,
  input wire logic        i_calib_busy_o,
  input wire logic [5:0]  q_calib_ref_o,
  input wire logic [5:0]  i_calib_ref_o
);
  logic [7:0] cal_ctl_m;
  // a write that completes at this edge, and its register index
  wire logic       done_w = write_i && !waitrequest_o && byteenable_i[0];
  wire logic [7:0] idx_w  = address_i[9:2];

  // mirror of calibration control, the checker cannot see inside
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cal_ctl_m <= 8'h00;
    end else if (done_w && idx_w == 8'h0e) begin
      cal_ctl_m <= writedata_i[7:0];
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence fast_tick;
    calib_clock_tick_o && cal_ctl_m[3] && cal_ctl_m[2:0] == 3'h7;
  endsequence
  sequence gate_held_off;
    !cal_ctl_m[3] [*3];
  endsequence

  AST_ONE_WAIT: assert property ($rose(read_i || write_i) |-> waitrequest_o ##1 !waitrequest_o)
    else $error("wait state count wrong");
  AST_LEVEL_LOW: assert property (done_w && idx_w == 8'h0b |=> aux_i_level_o[7:0] == $past(writedata_i[7:0]))
    else $error("level low byte wrong");
  AST_CTL_FIELDS: assert property (done_w && idx_w == 8'h0c |=>
    {aux_i_output_on_o, aux_i_span_sel_o, aux_i_ceiling_sel_o, aux_i_level_o[9:8]} == $past(writedata_i[7:0]))
    else $error("aux control fields wrong");
  AST_LEVEL_HOLD: assert property (!(done_w && (idx_w == 8'h0b || idx_w == 8'h0c)) |=> $stable(aux_i_level_o))
    else $error("level word changed without a write");
  AST_TRIM: assert property (done_w && idx_w == 8'h0d |=> reference_trim_code_o == $past(writedata_i[5:0]))
    else $error("trim code wrong");
  AST_READ_UPPER: assert property (read_i && !waitrequest_o |-> readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_TICK_SINGLE: assert property (calib_clock_tick_o |=> !calib_clock_tick_o)
    else $error("tick longer than one cycle");
  AST_TICK_GATE: assert property (gate_held_off |-> !calib_clock_tick_o)
    else $error("calibration tick while gate off");
  AST_DIV_TWO: assert property (fast_tick ##1 (cal_ctl_m[3] && cal_ctl_m[2:0] == 3'h7) |=> calib_clock_tick_o)
    else $error("divide by two period wrong");
  AST_LAUNCH_I: assert property (done_w && idx_w == 8'h12 && writedata_i[4] && !writedata_i[0]
    && cal_ctl_m[4] && !i_calib_busy_o |=> i_calib_busy_o)
    else $error("launch did not start");
  AST_NO_LAUNCH: assert property (done_w && idx_w == 8'h12 && !writedata_i[4] && !i_calib_busy_o
    |=> !i_calib_busy_o)
    else $error("sequencer started without launch");
  AST_RESET_STATE: assert property (disable iff (1'b0) reset_i |=>
    readdata_o == 32'h00000000 && !calib_clock_tick_o && !q_calib_busy_o && !i_calib_busy_o)
    else $error("outputs not cleared by reset");
endmodule

// file: test/aux_ref_cal_config_regs_test.sv
// self-checking bench for the aux, reference and calibration register slice
`timescale 1ns/1ps
module aux_ref_cal_config_regs_test;
  import cal_pkg::*;
  localparam logic [15:0] CAL_TICKS = 16'h0004;
  logic        clk_sys_i, reset_i, read_i, write_i;
  logic [9:0]  address_i;
  logic [3:0]  byteenable_i;
  logic [31:0] writedata_i, readdata_o, q;
  logic        waitrequest_o, aux_i_output_on_o, calib_clock_tick_o, q_calib_busy_o, i_calib_busy_o;
  logic [9:0]  aux_i_level_o;
  logic [1:0]  aux_i_span_sel_o;
  logic [2:0]  aux_i_ceiling_sel_o;
  logic [5:0]  reference_trim_code_o, q_calib_ref_o, i_calib_ref_o;
  int          mismatches, comparisons, n;
  logic [9:0]  lvls [3] = '{10'h3ff, 10'h200, 10'h000};
  logic [5:0]  trims [4] = '{6'h00, 6'h1f, 6'h20, 6'h3f};

  aux_ref_cal_config_regs #(.CAL_TICKS(CAL_TICKS), .MEM_DEPTH(64)) aux_ref_cal_config_regs_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .aux_i_level_o(aux_i_level_o), .aux_i_output_on_o(aux_i_output_on_o),
    .aux_i_span_sel_o(aux_i_span_sel_o), .aux_i_ceiling_sel_o(aux_i_ceiling_sel_o),
    .reference_trim_code_o(reference_trim_code_o), .calib_clock_tick_o(calib_clock_tick_o),
    .q_calib_busy_o(q_calib_busy_o), .i_calib_busy_o(i_calib_busy_o), .q_calib_ref_o(q_calib_ref_o),
    .i_calib_ref_o(i_calib_ref_o));

  // 25 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic end_of_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one avalon access; held until waitrequest is sampled low, then a spare edge
  // so the next call never reassigns the strobe in the same time step
  task automatic access(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic be);
    int k;
    k = 0;
    read_i       <= !w;
    write_i      <= w;
    address_i    <= {idx, 2'b00};
    writedata_i  <= {24'h000000, d};
    byteenable_i <= {3'b000, be};
    @(posedge clk_sys_i);
    while (waitrequest_o !== 1'b0 && k < 16) begin
      @(posedge clk_sys_i);
      k++;
    end
    if (k == 16) mismatches++;
    q = readdata_o;
    read_i  <= 1'b0;
    write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    access(1'b1, idx, d, 1'b1);
  endtask

  task automatic rdc(input string name, input logic [7:0] idx, input logic [31:0] exp);
    access(1'b0, idx, 8'h00, 1'b1);
    check(name, q, exp);
  endtask

  // cycles up to the next calibration tick, bounded
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge clk_sys_i);
      c++;
    end while (calib_clock_tick_o !== 1'b1 && c < 600);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while ((q_calib_busy_o | i_calib_busy_o) !== 1'b0 && k < 200) begin
      @(posedge clk_sys_i);
      k++;
    end
    if (k == 200) mismatches++;
    @(posedge clk_sys_i);
  endtask

  // watchdog: the sequence needs under two thousand cycles
  initial begin
    #(40 * 20000);
    mismatches++;
    end_of_test();
  end

  initial begin
    reset_i = 1'b1;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = 10'h000;
    byteenable_i = 4'h0;
    writedata_i = 32'h00000000;
    mismatches = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    // every readable register, 0x0b to 0x11, starts at zero
    for (int a = 8'h0b; a <= 8'h11; a++) rdc("reset value", 8'(a), 32'h0);
    check("i ref reset", i_calib_ref_o, 32'h20);
    // span and ceiling codes, also the two high level bits
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 5; c++) begin
        wr(8'h0c, {1'b1, 2'(s), 3'(c), 2'(s)});
        check("span", aux_i_span_sel_o, s);
        check("ceiling", aux_i_ceiling_sel_o, c);
        check("output on", aux_i_output_on_o, 1);
        rdc("aux control", 8'h0c, {24'h0, 1'b1, 2'(s), 3'(c), 2'(s)});
      end
    end
    // full, mid and bottom of scale split across two registers
    foreach (lvls[i]) begin
      wr(8'h0b, lvls[i][7:0]);
      wr(8'h0c, {6'h00, lvls[i][9:8]});
      check("level", aux_i_level_o, lvls[i]);
      check("output off", aux_i_output_on_o, 0);
    end
    foreach (trims[i]) begin
      wr(8'h0d, {2'b11, trims[i]});
      check("trim", reference_trim_code_o, trims[i]);
    end
    // refused writes: no byte enable, unmapped, read-only status
    wr(8'h0b, 8'h5a);
    access(1'b1, 8'h0b, 8'ha5, 1'b0);
    rdc("byteenable off", 8'h0b, 32'h5a);
    wr(8'h30, 8'hff);
    rdc("unmapped", 8'h30, 32'h0);
    wr(8'h0f, 8'hff);
    rdc("status read only", 8'h0f, 32'h0);
    // store then load back through the data register, top and user-preload slots
    for (int p = 0; p < 2; p++) begin
      wr(8'h10, p ? 8'h01 : 8'h3f);
      rdc("pointer", 8'h10, p ? 32'h01 : 32'h3f);
      wr(8'h11, p ? 8'h15 : 8'h2a);
      wr(8'h12, 8'h08);
      wr(8'h11, 8'h00);
      wr(8'h12, 8'h04);
      rdc("loaded word", 8'h11, p ? 32'h15 : 32'h2a);
    end
    // divider period for every code, measured between two ticks
    for (int d = 0; d < 8; d++) begin
      wr(8'h0e, 8'h08 | 8'(d));
      wait_tick(n);
      wait_tick(n);
      check("tick period", n, 256 >> d);
    end
    // in-phase self calibration with fixed preload
    wr(8'h0e, 8'h1f);
    wr(8'h12, 8'h00);
    check("no launch", i_calib_busy_o, 0);
    wr(8'h12, 8'h10);
    check("i busy", i_calib_busy_o, 1);
    check("q idle", q_calib_busy_o, 0);
    check("i preload", i_calib_ref_o, 32'h20);
    wait_idle();
    rdc("i done", 8'h0f, 32'h41);
    // quadrature with the user preload from slot one
    wr(8'h0e, 8'haf);
    wr(8'h12, 8'h10);
    check("q busy", q_calib_busy_o, 1);
    check("q preload", q_calib_ref_o, 32'h15);
    wait_idle();
    rdc("both done", 8'h0f, 32'hc5);
    wr(8'h12, 8'h02);
    rdc("q restored", 8'h0f, 32'hc1);
    wr(8'h12, 8'h80);
    rdc("q done cleared", 8'h0f, 32'h41);
    wr(8'h0e, 8'h1f);
    wr(8'h12, 8'h08);
    rdc("i user state", 8'h0f, 32'h42);
    wr(8'h12, 8'h41);
    rdc("i cleared", 8'h0f, 32'h00);
    end_of_test();
  end
endmodule

bind aux_ref_cal_config_regs aux_ref_cal_checker #(.CAL_TICKS(CAL_TICKS)) aux_ref_cal_checker_i (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
  .byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .aux_i_level_o(aux_i_level_o), .aux_i_output_on_o(aux_i_output_on_o),
  .aux_i_span_sel_o(aux_i_span_sel_o), .aux_i_ceiling_sel_o(aux_i_ceiling_sel_o),
  .reference_trim_code_o(reference_trim_code_o), .calib_clock_tick_o(calib_clock_tick_o),
  .q_calib_busy_o(q_calib_busy_o), .i_calib_busy_o(i_calib_busy_o), .q_calib_ref_o(q_calib_ref_o),
  .i_calib_ref_o(i_calib_ref_o));
